// >>> data_address_generator.sv
// Data address generator: direct paging, aux registers, post-modify
//
// Overview of operation
// (RQ1) Data space is 512 pages of 128 words
// (RQ2) Page comes from 9-bit status pointer
// (RQ3) Offset is low seven instruction bits
// (RQ4) Bits 15:8 hold type and shift
// (RQ5) Address is page high, offset low
// (RQ6) Reset leaves page pointer unchanged
// (RQ7) Page load alters only the pointer
// (RQ8) Shift of 16 comes from opcode
// (RQ9) No-shift opcodes use all eight bits
// (RQ10) Eight 16-bit aux address registers
// (RQ11) Three-bit pointer selects current aux register
// (RQ12) Pointer loaded by modify, status, indirect
// (RQ13) Current aux register drives read/write bus
// (RQ14) Unsigned 16-bit increment or decrement after use
// (RQ15) Updates finish in the decode stage
// (RQ16) Exponent align updates in execute stage
// (RQ17) Index modify by register zero, reverse carry
// (RQ18) Old pointer copied to pointer buffer
// (RQ19) Bit 7 selects direct or indirect
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module data_address_generator
(
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire dag_pkg::dec_req_t DEC_REQ_I,
   input wire logic EXEC_I,
   input wire logic [3:0] BUS_ADDR_I,
   input wire logic [15:0] BUS_WDATA_I,
   input wire logic BUS_WR_I,
   input wire logic BUS_RD_I,
   output logic [15:0] BUS_RDATA_O,
   output logic [15:0] DATA_READ_ADDR_O,
   output logic DATA_READ_VALID_O,
   output logic [15:0] DATA_WRITE_ADDR_O,
   output logic DATA_WRITE_VALID_O,
   output dag_pkg::shift_info_t SHIFT_INFO_O,
   output logic EXPONENT_ALIGN_INSTR_PENDING_O
);
   // ----------------------------------------------------------------
   // Types and storage
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXPONENT_ALIGN_INSTR_WAIT = 2'b10
   } exponent_align_instr_state_t;
   exponent_align_instr_state_t state_reg;                  // Deferred-modify tracker
   logic [8:0] dp_reg;                      // data_page_pointer
   logic [2:0] arp_reg;                     // aux_reg_pointer
   logic [3:0] misc_reg;                    // Other status bits
   logic [2:0] arb_reg;                     // pointer_buffer_reg
   logic [15:0] ar_reg [dag_pkg::NUM_AR];   // aux_address_registers
   logic [2:0] pend_ar_reg;                 // Deferred target index
   dag_pkg::post_mod_t pend_pm_reg;         // Deferred modify option
   logic pend_nar_ld_reg;                   // Deferred pointer load
   logic [2:0] pend_nar_reg;                // Deferred pointer value
   // ----------------------------------------------------------------
   // Decode of the request
   // ----------------------------------------------------------------
   dag_pkg::dec_req_t req;                  // Local copy of request
   logic indirect;                          // Bit 7 indicator
   logic [6:0] offset;                      // In-page offset
   logic [15:0] direct_addr;                // Page joined with offset
   logic [15:0] cur_ar_val;                 // Current aux register
   assign req = DEC_REQ_I;
   instr_field_decoder u_fields
   (
      .instr_i(req.instr),
      .cls_i(req.cls),
      .indirect_o(indirect),  // [RQ19]
      .offset_o(offset),
      .info_o(SHIFT_INFO_O)   // [RQ4] [RQ8] [RQ9]
   );
   // Page forms the upper nine bits, so 512 pages of 128 words
   assign direct_addr = {dp_reg, offset}; // [RQ1] [RQ2] [RQ3] [RQ5]
   assign cur_ar_val = ar_reg[arp_reg];   // [RQ11]
   // ----------------------------------------------------------------
   // Modify control
   // ----------------------------------------------------------------
   logic ind_dec;        // Indirect instruction in decode
   logic dec_mod;        // Modify now, in decode stage
   logic exec_mod;       // Deferred modify, in execute stage
   logic dec_nar;        // Pointer load in decode stage
   logic exec_nar;       // Pointer load in execute stage
   logic arp_load;       // Any pointer load this cycle
   logic [2:0] arp_next; // New pointer value
   logic bus_st0_wr;     // Software writes the status word
   logic bus_ar_wr;      // Software writes an aux register
   logic [2:0] mod_idx;  // Register the unit modifies
   dag_pkg::post_mod_t mod_op; // Option the unit applies
   logic [15:0] mod_res; // Modified register value
   assign ind_dec = req.valid & indirect;
   assign dec_mod = ind_dec & ~req.is_exponent_align_instr;           // [RQ15]
   assign exec_mod = (state_reg == ST_EXPONENT_ALIGN_INSTR_WAIT) & EXEC_I; // [RQ16]
   assign dec_nar = ind_dec & ~req.is_exponent_align_instr & req.nar_load; // [RQ12]
   assign exec_nar = exec_mod & pend_nar_ld_reg;
   assign bus_st0_wr = BUS_WR_I & (BUS_ADDR_I == dag_pkg::REG_ST0);
   assign bus_ar_wr = BUS_WR_I & BUS_ADDR_I[3];
   // Deferred work takes the slot; a decode modify in that same cycle is dropped
   assign mod_idx = exec_mod ? pend_ar_reg : arp_reg;
   assign mod_op = exec_mod ? pend_pm_reg : req.pm;
   aux_arith_unit u_arith
   (
      .cur_i(ar_reg[mod_idx]),
      .idx_i(ar_reg[0]),  // [RQ17]
      .op_i(mod_op),
      .res_o(mod_res)     // [RQ14]
   );
   // Pointer sources by priority: execute, decode, status, software
   always_comb
   begin
      arp_load = 1'b1;
      arp_next = arp_reg;
      if (exec_nar)
      begin
         arp_next = pend_nar_reg;  // [RQ16]
      end
      else if (dec_nar)
      begin
         arp_next = req.nar;       // [RQ12]
      end
      else if (req.valid & req.load_status_instr)
      begin
         arp_next = req.ld_data[dag_pkg::ARP_LSB +: dag_pkg::ARP_W];
      end
      else if (bus_st0_wr)
      begin
         arp_next = BUS_WDATA_I[dag_pkg::ARP_LSB +: dag_pkg::ARP_W];
      end
      else
      begin
         arp_load = 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Status word: pointer, spare bits, page; pointer buffer
   // ----------------------------------------------------------------
   // Pointer and buffer, reset to a known register
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         arp_reg <= dag_pkg::ARP_RST;
         arb_reg <= dag_pkg::ARP_RST;
      end
      else if (arp_load)
      begin
         arp_reg <= arp_next;  // [RQ11] [RQ12]
         arb_reg <= arp_reg;   // [RQ18]
      end
   end
   // Page pointer has no reset: software must load it first
   always_ff @(posedge REF_CLK_I)
   begin
      if (req.valid & req.load_page_instr)
      begin
         dp_reg <= req.ld_data[dag_pkg::PAGE_W-1:0]; // [RQ7]
      end
      else if (req.valid & req.load_status_instr)
      begin
         dp_reg <= req.ld_data[dag_pkg::DP_LSB +: dag_pkg::PAGE_W]; // [RQ7]
      end
      else if (bus_st0_wr)
      begin
         dp_reg <= BUS_WDATA_I[dag_pkg::DP_LSB +: dag_pkg::PAGE_W];
      end
   end // [RQ6]
   // Set by the first page, status or software status-word load and never cleared; unknown until then,
   // so the reset check below skips the power-up value of the page
   logic dp_known_reg; // Page loaded since power-up
   always_ff @(posedge REF_CLK_I)
   begin
      if ((req.valid & (req.load_page_instr | req.load_status_instr)) | bus_st0_wr)
      begin
         dp_known_reg <= 1'b1; // [RQ6]
      end
   end
   // Spare status bits ride along with whole-word loads only
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         misc_reg <= dag_pkg::MISC_RST;
      end
      else if (req.valid & req.load_status_instr)
      begin
         misc_reg <= req.ld_data[dag_pkg::MISC_LSB +: dag_pkg::MISC_W];
      end
      else if (bus_st0_wr)
      begin
         misc_reg <= BUS_WDATA_I[dag_pkg::MISC_LSB +: dag_pkg::MISC_W];
      end
   end
   // ----------------------------------------------------------------
   // Aux address registers
   // ----------------------------------------------------------------
   // Hardware modify beats a software write to the same cycle
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         for (int i = 0; i < dag_pkg::NUM_AR; i++)
         begin
            ar_reg[i] <= dag_pkg::AR_RST;
         end
      end
      else if (exec_mod | dec_mod)
      begin
         ar_reg[mod_idx] <= mod_res; // [RQ10] [RQ14] [RQ15] [RQ16]
      end
      else if (bus_ar_wr)
      begin
         ar_reg[BUS_ADDR_I[2:0]] <= BUS_WDATA_I;
      end
   end
   // ----------------------------------------------------------------
   // Deferred modify for exponent align
   // ----------------------------------------------------------------
   // One pending slot; the pipeline issues nothing else until execute
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         state_reg <= ST_IDLE;
         pend_ar_reg <= dag_pkg::ARP_RST;
         pend_pm_reg <= dag_pkg::PM_NONE;
         pend_nar_ld_reg <= 1'b0;
         pend_nar_reg <= dag_pkg::ARP_RST;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (ind_dec & req.is_exponent_align_instr)
               begin
                  state_reg <= ST_EXPONENT_ALIGN_INSTR_WAIT; // [RQ16]
                  pend_ar_reg <= arp_reg;
                  pend_pm_reg <= req.pm;
                  pend_nar_ld_reg <= req.nar_load;
                  pend_nar_reg <= req.nar;
               end
            end
            ST_EXPONENT_ALIGN_INSTR_WAIT:
            begin
               if (EXEC_I)
               begin
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
   assign EXPONENT_ALIGN_INSTR_PENDING_O = (state_reg == ST_EXPONENT_ALIGN_INSTR_WAIT);
   // ----------------------------------------------------------------
   // Address buses
   // ----------------------------------------------------------------
   // Address registered one cycle after decode
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         DATA_READ_ADDR_O <= dag_pkg::AR_RST;
         DATA_WRITE_ADDR_O <= dag_pkg::AR_RST;
         DATA_READ_VALID_O <= 1'b0;
         DATA_WRITE_VALID_O <= 1'b0;
      end
      else
      begin
         DATA_READ_VALID_O <= req.valid & req.rd;
         DATA_WRITE_VALID_O <= req.valid & req.wr;
         if (req.valid & req.rd)
         begin
            DATA_READ_ADDR_O <= indirect ? cur_ar_val : direct_addr; // [RQ13]
         end
         if (req.valid & req.wr)
         begin
            DATA_WRITE_ADDR_O <= indirect ? cur_ar_val : direct_addr; // [RQ13]
         end
      end
   end
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         BUS_RDATA_O <= dag_pkg::AR_RST;
      end
      else if (BUS_RD_I)
      begin
         if (BUS_ADDR_I[3])
         begin
            BUS_RDATA_O <= ar_reg[BUS_ADDR_I[2:0]];
         end
         else if (BUS_ADDR_I == dag_pkg::REG_ST0)
         begin
            BUS_RDATA_O <= {arp_reg, misc_reg, dp_reg};
         end
         else if (BUS_ADDR_I == dag_pkg::REG_ARB)
         begin
            BUS_RDATA_O <= {13'h0000, arb_reg};
         end
         else
         begin
            BUS_RDATA_O <= 16'h0000;
         end
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   direct_read_addr_a: assert property ( // [RQ5]
      req.valid && req.rd && !indirect |=>
      DATA_READ_ADDR_O == {$past(dp_reg), $past(req.instr[6:0])})
      else $error("direct read address wrong");
   indirect_read_addr_a: assert property ( // [RQ13]
      req.valid && req.rd && indirect |=>
      DATA_READ_VALID_O && DATA_READ_ADDR_O == $past(cur_ar_val))
      else $error("indirect read address wrong");
   indirect_write_addr_a: assert property ( // [RQ13]
      req.valid && req.wr && indirect |=>
      DATA_WRITE_VALID_O && DATA_WRITE_ADDR_O == $past(cur_ar_val))
      else $error("indirect write address wrong");
   page_load_a: assert property ( // [RQ7]
      req.valid && req.load_page_instr |=>
      dp_reg == $past(req.ld_data[8:0]) && $stable(misc_reg))
      else $error("page load wrong");
   buffer_copy_a: assert property ( // [RQ18]
      arp_load |=> arb_reg == $past(arp_reg))
      else $error("pointer buffer not updated");
   decode_inc_a: assert property ( // [RQ14]
      dec_mod && req.pm == dag_pkg::PM_INC && !exec_mod |->
      mod_res == cur_ar_val + 16'h0001)
      else $error("increment result wrong");
   exponent_align_instr_hold_a: assert property ( // [RQ16]
      state_reg == ST_EXPONENT_ALIGN_INSTR_WAIT && !EXEC_I && !req.valid && !BUS_WR_I
      |=> $stable(ar_reg[pend_ar_reg]) && $stable(arp_reg))
      else $error("deferred modify applied early");
   shift_sixteen_a: assert property ( // [RQ8]
      req.cls == dag_pkg::CLS_SHIFT16 |->
      SHIFT_INFO_O.shift == dag_pkg::SHIFT_16 && SHIFT_INFO_O.opcode == req.instr[15:8])
      else $error("implied shift wrong");
   page_reset_a: assert property ( // [RQ6]
      @(posedge REF_CLK_I) disable iff (1'b0)
      SYS_RST_I && dp_known_reg && !(req.valid && (req.load_page_instr || req.load_status_instr))
      && !bus_st0_wr |=> $stable(dp_reg))
      else $error("reset disturbed page pointer");
endmodule : data_address_generator

// >>> dag_pkg.sv
// Shared constants, types and helpers for the data address generator
package dag_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;   // Data address and word width
   localparam int PAGE_W = 9;    // Page pointer width
   localparam int OFS_W = 7;     // In-page offset width
   localparam int ARP_W = 3;     // Aux register pointer width
   localparam int MISC_W = 4;    // Other status bits kept here
   localparam int NUM_AR = 8;    // Number of aux address registers
   localparam int MODE_BIT = 7;  // Direct/indirect indicator bit
   localparam int OPC_LSB = 8;   // Low bit of the opcode byte
   // ----------------------------------------------------------------
   // Status word layout and register map
   // ----------------------------------------------------------------
   localparam int ARP_LSB = 13;  // Pointer field in bits 15:13
   localparam int MISC_LSB = 9;  // Spare status bits 12:9
   localparam int DP_LSB = 0;    // Page pointer in bits 8:0
   localparam logic [MISC_W-1:0] MISC_RST = 4'h0;
   localparam logic [ARP_W-1:0] ARP_RST = 3'h0;
   localparam logic [WORD_W-1:0] AR_RST = 16'h0000;
   localparam logic [3:0] REG_ST0 = 4'h0;    // status_word_zero
   localparam logic [3:0] REG_ARB = 4'h1;    // pointer_buffer_reg
   localparam logic [3:0] REG_AR0 = 4'h8;    // aux regs at 8..15
   localparam logic [4:0] SHIFT_16 = 5'h10;  // Implied shift amount
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PM_NONE = 3'h0, PM_INC = 3'h1, PM_DEC = 3'h2, PM_INC0 = 3'h3,
      PM_DEC0 = 3'h4, PM_BRINC = 3'h5, PM_BRDEC = 3'h6
   } post_mod_t;
   typedef enum logic [2:0] {
      CLS_NOSHIFT = 3'b001, CLS_SHIFTFLD = 3'b010, CLS_SHIFT16 = 3'b100
   } shift_class_t;
   typedef struct packed {
      logic valid;                 // Instruction in decode stage
      logic [WORD_W-1:0] instr;    // instr_word_reg content
      logic rd;                    // Reads data memory
      logic wr;                    // Writes data memory
      post_mod_t pm;               // Post-modify option
      logic nar_load;              // Loads next aux pointer
      logic [ARP_W-1:0] nar;       // Next aux pointer value
      logic is_exponent_align_instr;               // exponent_align_instr
      logic load_page_instr;                   // load_page_instr
      logic load_status_instr;                   // load_status_instr
      logic [WORD_W-1:0] ld_data;  // Operand for ldp / lst
      shift_class_t cls;           // Shift class of the opcode
   } dec_req_t;
   typedef struct packed {
      logic [7:0] opcode;          // Instruction type byte
      logic [4:0] shift;           // Data shift amount
      logic has_shift;             // A shift applies
   } shift_info_t;
   // ----------------------------------------------------------------
   // Reverse-carry helpers
   // ----------------------------------------------------------------
   function automatic logic [WORD_W-1:0] rev16(input logic [WORD_W-1:0] v);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < WORD_W; i++)
      begin
         r[i] = v[WORD_W-1-i];
      end
      return r;
   endfunction : rev16
   function automatic logic [WORD_W-1:0] rc_add(input logic [WORD_W-1:0] a,
                                                 input logic [WORD_W-1:0] b);
      logic [WORD_W-1:0] s;
      s = rev16(a) + rev16(b);
      return rev16(s);
   endfunction : rc_add
endpackage : dag_pkg

// >>> aux_arith_unit.sv
// Unsigned post-modify arithmetic for the current aux register
`timescale 1ns/1ps
module aux_arith_unit
(
   input wire logic [15:0] cur_i,
   input wire logic [15:0] idx_i,
   input wire dag_pkg::post_mod_t op_i,
   output logic [15:0] res_o
);
   // ----------------------------------------------------------------
   // Modify datapath
   // ----------------------------------------------------------------
   logic [15:0] neg_idx; // Two's complement of the index
   assign neg_idx = 16'h0000 - idx_i;
   // Wraps modulo 64K, no flags; reverse carry feeds FFT reordering
   always_comb
   begin
      unique case (op_i)
         dag_pkg::PM_NONE: res_o = cur_i;
         dag_pkg::PM_INC: res_o = cur_i + 16'h0001;
         dag_pkg::PM_DEC: res_o = cur_i - 16'h0001;
         dag_pkg::PM_INC0: res_o = cur_i + idx_i;
         dag_pkg::PM_DEC0: res_o = cur_i - idx_i;
         dag_pkg::PM_BRINC: res_o = dag_pkg::rc_add(cur_i, idx_i);
         dag_pkg::PM_BRDEC: res_o = dag_pkg::rc_add(cur_i, neg_idx);
         default: res_o = cur_i; // Unused code 7 holds the value
      endcase
   end
endmodule : aux_arith_unit

// >>> instr_field_decoder.sv
// Splits the instruction word into mode, offset and shift fields
`timescale 1ns/1ps
module instr_field_decoder
(
   input wire logic [15:0] instr_i,
   input wire dag_pkg::shift_class_t cls_i,
   output logic indirect_o,
   output logic [6:0] offset_o,
   output dag_pkg::shift_info_t info_o
);
   // ----------------------------------------------------------------
   // Field split
   // ----------------------------------------------------------------
   assign indirect_o = instr_i[dag_pkg::MODE_BIT];
   assign offset_o = instr_i[dag_pkg::OFS_W-1:0];
   // Upper byte is type plus optional shift nibble
   always_comb
   begin
      info_o.opcode = instr_i[dag_pkg::WORD_W-1:dag_pkg::OPC_LSB];
      info_o.shift = 5'h00;
      info_o.has_shift = 1'b0;
      unique case (cls_i)
         dag_pkg::CLS_SHIFTFLD:
         begin
            // Low nibble of the byte carries the shift
            info_o.opcode = {instr_i[15:12], 4'h0};
            info_o.shift = {1'b0, instr_i[11:8]};
            info_o.has_shift = 1'b1;
         end
         dag_pkg::CLS_SHIFT16:
         begin
            // Whole byte is opcode, shift implied by it
            info_o.shift = dag_pkg::SHIFT_16;
            info_o.has_shift = 1'b1;
         end
         dag_pkg::CLS_NOSHIFT:
         begin
            info_o.has_shift = 1'b0; // All eight bits are opcode
         end
         default:
         begin
            info_o.has_shift = 1'b0;
         end
      endcase
   end
endmodule : instr_field_decoder

// >>> dag_pipe_model.sv
// Decode pipeline stand-in that drives the decode and execute ports
`timescale 1ns/1ps
module dag_pipe_model
(
   input wire logic clk_i,
   output dag_pkg::dec_req_t req_o,
   output logic exec_o
);
   // ----------------------------------------------------------------
   // Idle levels at time zero
   // ----------------------------------------------------------------
   initial
   begin
      req_o = '0;
      req_o.cls = dag_pkg::CLS_NOSHIFT;
      exec_o = 1'b0;
   end
   // One decode, held until its sampling edge; instr inverted after
   // release so a stale word never looks like a fresh one
   task automatic issue(input dag_pkg::dec_req_t r);
      @(posedge clk_i);
      req_o <= r;
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      req_o.instr <= ~r.instr;
   endtask : issue
   // Present a word without a decode, for the shift field view
   task automatic show(input dag_pkg::dec_req_t r);
      @(posedge clk_i);
      req_o <= r;
   endtask : show
   // Execute stage of a deferred modify
   task automatic exec_pulse();
      @(posedge clk_i);
      exec_o <= 1'b1;
      @(posedge clk_i);
      exec_o <= 1'b0;
   endtask : exec_pulse
endmodule : dag_pipe_model

// >>> data_address_generator_bench.sv
// Self-checking bench for the data address generator
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("mismatch %s exp %h got %h", what, exp, got); \
      end \
   end
module data_address_generator_bench;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata, ra, wa;
   logic rv, wv, pend, exec;
   dag_pkg::dec_req_t req, r;
   dag_pkg::shift_info_t si;
   logic [15:0] exp_ar [8];   // Bench copy of the aux registers
   logic [15:0] cur;
   int miscompares = 0;
   int n_tests = 0;
   initial
   begin
      forever #20 clk = ~clk;
   end
   dag_pipe_model u_pipe (.clk_i(clk), .req_o(req), .exec_o(exec));
   data_address_generator u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .DEC_REQ_I(req),
      .EXEC_I(exec), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .BUS_WR_I(wr),
      .BUS_RD_I(rd), .BUS_RDATA_O(rdata), .DATA_READ_ADDR_O(ra),
      .DATA_READ_VALID_O(rv), .DATA_WRITE_ADDR_O(wa), .DATA_WRITE_VALID_O(wv),
      .SHIFT_INFO_O(si), .EXPONENT_ALIGN_INSTR_PENDING_O(pend));
   // ----------------------------------------------------------------
   // Register bus tasks and expectation helpers
   // ----------------------------------------------------------------
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr
   // Read data is only looked at in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string n);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(n, e, rdata)
   endtask : rd_chk
   function automatic dag_pkg::dec_req_t mk(input logic [15:0] ins, input logic rr,
      input logic ww, input dag_pkg::post_mod_t p);
      dag_pkg::dec_req_t q;
      q = '0;
      q.valid = 1'b1;
      q.instr = ins;
      q.rd = rr;
      q.wr = ww;
      q.pm = p;
      q.cls = dag_pkg::CLS_NOSHIFT;
      return q;
   endfunction : mk
   function automatic logic [15:0] rev(input logic [15:0] v);
      logic [15:0] o;
      for (int b = 0; b < 16; b++)
      begin
         o[b] = v[15-b];
      end
      return o;
   endfunction : rev
   // Post-modify result by option code, unsigned wrap on purpose
   function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] x, input int k);
      case (k)
         1: return c + 16'h0001;
         2: return c - 16'h0001;
         3: return c + x;
         4: return c - x;
         5: return rev(rev(c) + rev(x));
         6: return rev(rev(c) + rev(-x));
         default: return c;
      endcase
   endfunction : nxt
   // ----------------------------------------------------------------
   // Verdict and watchdog
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (4000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk(4'h1, 16'h0000, "buffer reset");
      rd_chk(4'h5, 16'h0000, "unmapped");
      r = mk(16'h0000, 1'b0, 1'b0, dag_pkg::PM_NONE);
      r.load_page_instr = 1'b1;
      r.ld_data = 16'h0004;
      u_pipe.issue(r);
      rd_chk(4'h0, 16'h0004, "status after page load");
      u_pipe.issue(mk(16'h2509, 1'b1, 1'b0, dag_pkg::PM_NONE));
      #1;
      `CHK("direct read", 17'h10209, {rv, ra})
      r.ld_data = 16'h01ff;
      u_pipe.issue(r);
      u_pipe.issue(mk(16'h397f, 1'b0, 1'b1, dag_pkg::PM_NONE));
      #1;
      `CHK("last page write", 18'h1ffff, {rv, wv, wa})
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(4'h0, 16'h01ff, "page kept over reset");
      // Aux registers loaded by software; register one set to wrap
      for (int i = 0; i < 8; i++)
      begin
         exp_ar[i] = 16'(i) * 16'h1111 + 16'h0010;
         rd_chk(4'(8 + i), 16'h0000, "aux reset");
         bus_wr(4'(8 + i), exp_ar[i]);
      end
      exp_ar[1] = 16'hffff;
      bus_wr(4'h9, exp_ar[1]);
      r = mk(16'h0080, 1'b0, 1'b0, dag_pkg::PM_NONE);
      r.nar_load = 1'b1;
      r.nar = 3'h1;
      u_pipe.issue(r);
      // Every option code, reads and writes alternating
      for (int k = 0; k < 7; k++)
      begin
         u_pipe.issue(mk(16'h0080, k[0], ~k[0], dag_pkg::post_mod_t'(k)));
         #1;
         cur = k[0] ? ra : wa;
         `CHK("indirect bus", {k[0], ~k[0], exp_ar[1]}, {rv, wv, cur})
         exp_ar[1] = nxt(exp_ar[1], exp_ar[0], k);
         rd_chk(4'h9, exp_ar[1], "post modify");
      end
      r = mk(16'h0080, 1'b1, 1'b0, dag_pkg::PM_INC);
      r.nar_load = 1'b1;
      r.nar = 3'h2;
      u_pipe.issue(r);
      rd_chk(4'h1, 16'h0001, "buffer after side load");
      u_pipe.issue(mk(16'h0080, 1'b1, 1'b0, dag_pkg::PM_NONE));
      #1;
      `CHK("new current reg", exp_ar[2], ra)
      r = mk(16'h0000, 1'b0, 1'b0, dag_pkg::PM_NONE);
      r.load_status_instr = 1'b1;
      r.ld_data = 16'ha033;
      u_pipe.issue(r);
      rd_chk(4'h0, 16'ha033, "status load");
      rd_chk(4'h1, 16'h0002, "buffer after status load");
      // Exponent align: modify waits for the execute stage
      r = mk(16'h0080, 1'b1, 1'b0, dag_pkg::PM_INC);
      r.is_exponent_align_instr = 1'b1;
      r.nar_load = 1'b1;
      r.nar = 3'h3;
      u_pipe.issue(r);
      #1;
      `CHK("exponent_align_instr pending", {1'b1, exp_ar[5]}, {pend, ra})
      rd_chk(4'hd, exp_ar[5], "aux held until execute");
      u_pipe.exec_pulse();
      #1;
      `CHK("exponent_align_instr done", 1'b0, pend)
      rd_chk(4'hd, exp_ar[5] + 16'h0001, "aux after execute");
      rd_chk(4'h1, 16'h0005, "buffer after execute");
      // Shift field view by class
      r = mk(16'h6a05, 1'b0, 1'b0, dag_pkg::PM_NONE);
      r.valid = 1'b0;
      r.cls = dag_pkg::CLS_SHIFT16;
      u_pipe.show(r);
      #1;
      `CHK("shift 16", {8'h6a, 5'h10, 1'b1}, {si.opcode, si.shift, si.has_shift})
      r.cls = dag_pkg::CLS_NOSHIFT;
      u_pipe.show(r);
      #1;
      `CHK("no shift", 9'h0d4, {si.opcode, si.has_shift})
      r.instr = 16'h2509;
      r.cls = dag_pkg::CLS_SHIFTFLD;
      u_pipe.show(r);
      #1;
      `CHK("shift field", 13'h0405, {si.opcode, si.shift})
      give_verdict();
   end
endmodule : data_address_generator_bench
